// ### src/ctt_params.svh
`ifndef CTT_PARAMS_SVH
`define CTT_PARAMS_SVH
// Register byte addresses on the APB
`define CTT_ADDR_PRIO     16'hFF20
`define CTT_ADDR_ENABLE   16'hFF22
`define CTT_ADDR_FLAGS    16'hFF24
`define CTT_ADDR_CTRL     16'hFF40
`define CTT_ADDR_COUNT    16'hFF41
`define CTT_ADDR_WIDTH    16
// Control register fields
`define CTT_CTRL_RUN      0
`define CTT_CTRL_CLEAR    1
`define CTT_CTRL_WDOG     2
`define CTT_CTRL_GATE     3
`define CTT_CTRL_SEL_LO   4
`define CTT_CTRL_SEL_HI   6
// Reset values
`define CTT_RST_BYTE      8'h00
`define CTT_RST_LEVEL     2'h0
// Tap bits for flag sources: 1, 2, 8, 32 Hz
`define CTT_TAP_1HZ       7
`define CTT_TAP_2HZ       6
`define CTT_TAP_8HZ       4
`define CTT_TAP_32HZ      2
// Timing
`define CTT_TICK_HZ       256
`define CTT_LOW_OSC_HZ    32768
`endif

// ### src/ctt_pkg.sv
package ctt_pkg;
  typedef logic [1:0] ctt_level_t;
  typedef logic [7:0] ctt_byte_t;
endpackage

// ### src/clock_tick_timer.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "ctt_params.svh"

module clock_tick_timer
  import ctt_pkg::*;
#(
  parameter int LOW_OSC_HZ = `CTT_LOW_OSC_HZ
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lowOscClk,
  input  wire logic        highOscClk,
  input  wire logic [1:0]  cpuMaskLevel,
  output logic             irqRequest,
  output ctt_level_t       irqLevel,
  output logic             watchdogClear,
  output logic             freqOutput
);

  localparam int TICK_DIV = LOW_OSC_HZ / `CTT_TICK_HZ;

  // ********************************
  // Parameter checks
  // ********************************
  // Divider of at least two, within the sixteen bit counter
  if (TICK_DIV < 2 || TICK_DIV > 65536) begin : g_bad_div
    $error("LOW_OSC_HZ gives a tick divider out of range");
  end

  // Oscillator rate a whole number of ticks
  if (LOW_OSC_HZ % `CTT_TICK_HZ != 0) begin : g_bad_rate
    $error("LOW_OSC_HZ must be a whole multiple of the tick rate");
  end

  // ********************************
  // Oscillator input synchronisers
  // ********************************
  logic [2:0] lowSync_r;
  logic [2:0] highSync_r;
  logic       lowOsc_r;
  logic       highOsc_r;
  logic       lowRise;
  logic       highRise;

  // Low oscillator three stage sync
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lowSync_r <= 3'h0;
      lowOsc_r  <= 1'b0;
    end else begin
      lowSync_r <= {lowSync_r[1:0], lowOscClk};
      if (lowSync_r[1] == lowSync_r[2])
        lowOsc_r <= lowSync_r[2];
    end
  end

  // High oscillator three stage sync
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      highSync_r <= 3'h0;
      highOsc_r  <= 1'b0;
    end else begin
      highSync_r <= {highSync_r[1:0], highOscClk};
      if (highSync_r[1] == highSync_r[2])
        highOsc_r <= highSync_r[2];
    end
  end

  assign lowRise  = (lowSync_r[1] == lowSync_r[2]) && lowSync_r[2] && !lowOsc_r;
  assign highRise = (highSync_r[1] == highSync_r[2]) && highSync_r[2] && !highOsc_r;

  // ********************************
  // 256 Hz tick divider
  // ********************************
  logic [15:0] lowDiv_r;
  logic        tickFall;

  always_ff @(posedge ref_clk) begin
    if (rst)
      lowDiv_r <= 16'h0000;
    else if (lowRise)
      lowDiv_r <= (lowDiv_r == 16'(TICK_DIV - 1)) ? 16'h0000 : lowDiv_r + 16'h0001;
  end

  assign tickFall = lowRise && (lowDiv_r == 16'(TICK_DIV - 1));

  // ********************************
  // APB decode
  // ********************************
  logic wrEn;
  logic rdSetup;
  logic rdHit;
  logic selPrio;
  logic selEn;
  logic selFlag;
  logic selCtrl;
  logic selCount;

  assign selPrio  = paddr == `CTT_ADDR_PRIO;
  assign selEn    = paddr == `CTT_ADDR_ENABLE;
  assign selFlag  = paddr == `CTT_ADDR_FLAGS;
  assign selCtrl  = paddr == `CTT_ADDR_CTRL;
  assign selCount = paddr == `CTT_ADDR_COUNT;
  assign rdHit    = selPrio | selEn | selFlag | selCtrl | selCount;
  assign wrEn     = psel && penable && pwrite;
  // Read data captured in setup cycle
  assign rdSetup  = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !rdHit;

  // ********************************
  // Control registers
  // ********************************
  ctt_level_t  level_r;
  logic [3:0]  irqEn_r;
  logic [2:0]  freqSel_r;
  logic        freqGate_r;
  logic        runReq_r;
  logic        runAct_r;
  logic        clearPulse;

  always_ff @(posedge ref_clk) begin
    if (rst)
      level_r <= `CTT_RST_LEVEL;
    else if (wrEn && selPrio)
      level_r <= pwdata[1:0];
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      irqEn_r <= 4'h0;
    else if (wrEn && selEn)
      irqEn_r <= pwdata[3:0];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      freqSel_r  <= 3'h0;
      freqGate_r <= 1'b0;
    end else if (wrEn && selCtrl) begin
      freqSel_r  <= pwdata[`CTT_CTRL_SEL_HI:`CTT_CTRL_SEL_LO];
      freqGate_r <= pwdata[`CTT_CTRL_GATE];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      runReq_r <= 1'b0;
    else if (wrEn && selCtrl)
      runReq_r <= pwdata[`CTT_CTRL_RUN];
  end

  assign clearPulse    = wrEn && selCtrl && pwdata[`CTT_CTRL_CLEAR];
  // Watchdog clear strobe
  assign watchdogClear = wrEn && selCtrl && pwdata[`CTT_CTRL_WDOG];

  // ********************************
  // Run control
  // ********************************

  always_ff @(posedge ref_clk) begin
    if (rst)
      runAct_r <= 1'b0;
    else if (tickFall)
      runAct_r <= runReq_r;
  end

  // ********************************
  // Counter
  // ********************************
  ctt_byte_t count_r;
  logic      countStep;

  assign countStep = tickFall && runAct_r;

  always_ff @(posedge ref_clk) begin
    if (rst)
      count_r <= `CTT_RST_BYTE;
    else if (clearPulse)
      count_r <= `CTT_RST_BYTE;
    else if (countStep)
      count_r <= count_r + 8'h01;
  end

  // ********************************
  // Interrupt flags
  // ********************************
  logic [3:0] tapVec;
  logic [3:0] tapPrev_r;
  logic [3:0] tapFall;
  logic [3:0] flag_r;
  logic       irqAny;

  assign tapVec = {count_r[`CTT_TAP_32HZ], count_r[`CTT_TAP_8HZ],
                   count_r[`CTT_TAP_2HZ], count_r[`CTT_TAP_1HZ]};

  always_ff @(posedge ref_clk) begin
    if (rst)
      tapPrev_r <= 4'h0;
    else
      tapPrev_r <= tapVec;
  end

  // Falling taps
  assign tapFall = tapPrev_r & ~tapVec;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      always_ff @(posedge ref_clk) begin
        if (rst)
          flag_r[gi] <= 1'b0;
        else if (tapFall[gi])
          flag_r[gi] <= 1'b1;
        else if (wrEn && selFlag && pwdata[gi])
          flag_r[gi] <= 1'b0;
      end
    end
  endgenerate

  // Any enabled flag
  assign irqAny     = |(flag_r & irqEn_r);
  assign irqRequest = irqAny && (level_r > cpuMaskLevel);
  assign irqLevel   = level_r;

  // ********************************
  // Frequency output
  // ********************************
  logic [2:0] lowCnt_r;
  logic [2:0] highCnt_r;
  logic       freq_r;
  logic [2:0] srcCnt;
  logic       srcRise;
  logic       srcBit;

  // Low source edge counter
  always_ff @(posedge ref_clk) begin
    if (rst)
      lowCnt_r <= 3'h0;
    else if (lowRise)
      lowCnt_r <= lowCnt_r + 3'h1;
  end

  // High source edge counter
  always_ff @(posedge ref_clk) begin
    if (rst)
      highCnt_r <= 3'h0;
    else if (highRise)
      highCnt_r <= highCnt_r + 3'h1;
  end

  assign srcCnt  = freqSel_r[2] ? highCnt_r : lowCnt_r;
  assign srcRise = freqSel_r[2] ? highRise : lowRise;
  assign srcBit  = srcCnt[freqSel_r[1:0] - 2'h1];

  always_ff @(posedge ref_clk) begin
    if (rst)
      freq_r <= 1'b0;
    else if (!freqGate_r)
      freq_r <= 1'b0;
    else if (freqSel_r[1:0] == 2'h0)
      freq_r <= freqSel_r[2] ? highOsc_r : lowOsc_r;
    else if (srcRise)
      freq_r <= srcBit;
  end

  assign freqOutput = freq_r;

  // ********************************
  // Read data
  // ********************************
  logic [7:0] rdByte;

  always_comb begin
    rdByte = 8'h00;
    if (selPrio)
      rdByte = {6'h00, level_r};
    if (selEn)
      rdByte = {4'h0, irqEn_r};
    if (selFlag)
      rdByte = {4'h0, flag_r};
    if (selCtrl)
      rdByte = {1'b0, freqSel_r, freqGate_r, 2'h0, runReq_r | runAct_r};
    if (selCount)
      rdByte = count_r;
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (rdSetup)
      prdata <= {24'h00_0000, rdByte};
  end

endmodule // clock_tick_timer

// ### testbench/ctt_checker.sv
`timescale 1ns/1ps
`include "ctt_params.svh"
module ctt_checker
  import ctt_pkg::*;
#(
  parameter int LOW_OSC_HZ = 32768
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [1:0]  cpuMaskLevel,
  input wire logic        irqRequest,
  input wire ctt_level_t  irqLevel,
  input wire logic        freqOutput
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic acc;
  logic wPrio;
  assign acc = psel && penable;
  assign wPrio = acc && pwrite && paddr == `CTT_ADDR_PRIO;
  sequence s_rd(a);
    acc && !pwrite && paddr == a;
  endsequence
  a_reset_clean: assert property (
    $past(rst) |-> prdata == 32'h0 && !irqRequest && !freqOutput) else $error("reset state");
  a_ctrl_wonly: assert property (
    s_rd(`CTT_ADDR_CTRL) |-> prdata[2:1] == 2'h0) else $error("ctrl read bits");
  a_level_write: assert property (
    wPrio |=> irqLevel == $past(pwdata[1:0])) else $error("level write");
  a_level_hold: assert property (
    !wPrio |=> $stable(irqLevel)) else $error("level changed");
  a_irq_above: assert property (
    irqRequest |-> irqLevel > cpuMaskLevel) else $error("irq level");
  a_flag_bits: assert property (
    s_rd(`CTT_ADDR_FLAGS) |-> prdata[7:4] == 4'h0) else $error("flag bits");
  a_enable_bits: assert property (
    s_rd(`CTT_ADDR_ENABLE) |-> prdata[7:4] == 4'h0) else $error("enable bits");
  a_gate_off: assert property (
    acc && pwrite && paddr == `CTT_ADDR_CTRL && !pwdata[3] |-> ##3 !freqOutput)
    else $error("output not gated");
endmodule // ctt_checker
bind clock_tick_timer ctt_checker #(.LOW_OSC_HZ(LOW_OSC_HZ)) i_ctt_checker (
  .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .cpuMaskLevel, .irqRequest, .irqLevel, .freqOutput);

// ### testbench/clock_tick_timer_tb_top.sv
`timescale 1ns/1ps
`include "ctt_params.svh"
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin errTotal++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module clock_tick_timer_tb_top;
  import ctt_pkg::*;
  // ****
  // Bench
  // ****
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic lowOscClk = 1'b0, highOscClk = 1'b0, pready, pslverr, errResp, irqRequest;
  logic watchdogClear, freqOutput, fPrev, wdogSeen;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  cpuMaskLevel = 2'h0;
  logic [7:0]  c0;
  ctt_level_t  irqLevel;
  int          errTotal = 0, totalChecks = 0, cyc = 0, n;
  logic [15:0] rstAddr [5] = '{16'hFF20, 16'hFF22, 16'hFF24, 16'hFF40, 16'hFF41};
  logic [8:0]  foTbl [3] = '{9'h108, 9'h178, 9'h070};
  clock_tick_timer #(.LOW_OSC_HZ(512)) i_clock_tick_timer (
    .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .lowOscClk, .highOscClk, .cpuMaskLevel, .irqRequest, .irqLevel,
    .watchdogClear, .freqOutput);
  always #20 ref_clk = ~ref_clk;
  always #200 lowOscClk = ~lowOscClk;
  always #100 highOscClk = ~highOscClk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errTotal++;
      results();
    end
  end
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    errResp = pslverr;
    wdogSeen = watchdogClear;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask
  task automatic waitCnt(input logic [7:0] lo);
    do begin
      apb(1'b0, `CTT_ADDR_COUNT, 8'h00);
    end while (rd[7:0] < lo);
  endtask
  task results;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rstAddr[i]) rdc(rstAddr[i], 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `CTT_ADDR_PRIO, 8'(i));
      rdc(`CTT_ADDR_PRIO, 8'(i));
      `CHK(irqLevel, 2'(i))
    end
    apb(1'b1, `CTT_ADDR_ENABLE, 8'h0F);
    rdc(`CTT_ADDR_ENABLE, 8'h0F);
    apb(1'b1, `CTT_ADDR_COUNT, 8'hFF);
    rdc(`CTT_ADDR_COUNT, 8'h00);
    rdc(16'hFF21, 8'h00);
    `CHK(errResp, 1'b1)
    apb(1'b1, `CTT_ADDR_CTRL, 8'h01);
    waitCnt(8'h09);
    rdc(`CTT_ADDR_FLAGS, 8'h08);
    `CHK(irqRequest, 1'b1)
    cpuMaskLevel <= 2'h3;
    @(posedge ref_clk);
    `CHK(irqRequest, 1'b0)
    cpuMaskLevel <= 2'h0;
    apb(1'b1, `CTT_ADDR_ENABLE, 8'h00);
    rdc(`CTT_ADDR_ENABLE, 8'h00);
    `CHK(irqRequest, 1'b0)
    $display("register test done");
    apb(1'b0, `CTT_ADDR_COUNT, 8'h00);
    waitCnt(rd[7:0] + 8'h01);
    c0 = rd[7:0];
    apb(1'b1, `CTT_ADDR_CTRL, 8'h00);
    `CHK(wdogSeen, 1'b0)
    rdc(`CTT_ADDR_CTRL, 8'h01);
    repeat (60) @(posedge ref_clk);
    rdc(`CTT_ADDR_COUNT, c0 + 8'h01);
    rdc(`CTT_ADDR_CTRL, 8'h00);
    repeat (60) @(posedge ref_clk);
    rdc(`CTT_ADDR_COUNT, c0 + 8'h01);
    apb(1'b1, `CTT_ADDR_CTRL, 8'h06);
    `CHK(wdogSeen, 1'b1)
    repeat (60) @(posedge ref_clk);
    rdc(`CTT_ADDR_COUNT, 8'h00);
    rdc(`CTT_ADDR_CTRL, 8'h00);
    $display("run stop test done");
    apb(1'b1, `CTT_ADDR_FLAGS, 8'h0F);
    rdc(`CTT_ADDR_FLAGS, 8'h00);
    apb(1'b1, `CTT_ADDR_CTRL, 8'h01);
    repeat (5400) @(posedge ref_clk);
    rdc(`CTT_ADDR_FLAGS, 8'h0F);
    apb(1'b1, `CTT_ADDR_CTRL, 8'h00);
    repeat (60) @(posedge ref_clk);
    apb(1'b1, `CTT_ADDR_FLAGS, 8'h00);
    rdc(`CTT_ADDR_FLAGS, 8'h0F);
    apb(1'b1, `CTT_ADDR_FLAGS, 8'h05);
    rdc(`CTT_ADDR_FLAGS, 8'h0A);
    $display("flag test done");
    foreach (foTbl[i]) begin
      apb(1'b1, `CTT_ADDR_CTRL, foTbl[i][7:0]);
      repeat (10) @(posedge ref_clk);
      n = 0;
      fPrev = freqOutput;
      repeat (60) begin
        @(posedge ref_clk);
        n += int'(freqOutput !== fPrev);
        fPrev = freqOutput;
      end
      `CHK(n > 0, foTbl[i][8])
    end
    $display("freq out test done");
    results();
  end
endmodule // clock_tick_timer_tb_top
